// file: src/aelr_receiver.sv
// Protocol engine of the absolute encoder link receiver
module aelr_receiver
    import aelr_pkg::*;
#(
    parameter logic [7:0]  CRC_POLY = 8'h01,
    parameter int unsigned DEPTH    = 2
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire aelr_kind_t transactionCode,
    input  wire logic [7:0] memAddr,
    input  wire logic [7:0] memData,
    input  wire logic       rxd,
    output logic            txd,
    output logic            transmitEnable,
    output logic            busy,
    output logic            done,
    output logic            crcOk,
    output logic            crcFail,
    output logic            frameError,
    output logic            echoError,
    output logic            overrun,
    output logic [7:0]      replyData,
    output logic            replyValid,
    input  wire logic       replyReady
);

    //--------------------------------------------------------------------------
    // Sequencer state
    //--------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SEND  = 3'b001,
        ST_ECHO  = 3'b010,
        ST_RECV  = 3'b011,
        ST_CHECK = 3'b100,
        ST_DONE  = 3'b101
    } aelr_state_t;

    aelr_state_t state;
    aelr_kind_t  kind;
    logic [7:0]  addrHold;
    logic [7:0]  dataHold;
    logic [3:0]  reqIdx;
    logic [3:0]  rxIdx;
    logic [7:0]  txCrc;
    logic [7:0]  rxCrc;
    logic [7:0]  lastSent;

    //--------------------------------------------------------------------------
    // Bit-rate divider and transmitter
    //--------------------------------------------------------------------------
    logic [1:0] divCnt;
    logic       bitTick;
    logic [9:0] txShift;
    logic [3:0] txBits;
    logic       txActive;
    logic       txLoad;
    logic [7:0] txByte;
    wire  [3:0] reqLast = reqLen(kind) - 4'h1;

    // One enable pulse per bit time at 2.5 Mbps
    assign bitTick = (divCnt == 2'(CYC_PER_BIT - 1));
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) divCnt <= 2'h0;
        else divCnt <= bitTick ? 2'h0 : divCnt + 2'h1;
    end

    // Control, then address, then data on writes, CRC last
    assign txByte = (reqIdx == 4'h0)    ? ctrlOf(kind) :
                    (reqIdx == reqLast) ? txCrc :
                    (reqIdx == 4'h1)    ? addrHold : dataHold;
    // A byte leaves only on a bit boundary, once the echo of the last is in
    assign txLoad = (state == ST_SEND) && !txActive && bitTick;
    assign txd    = txActive ? txShift[0] : 1'b1;

    // Shift a ten-bit field: low start, payload LSB first, high delimiter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txShift  <= 10'h3FF;
            txBits   <= 4'h0;
            txActive <= 1'b0;
        end else if (txLoad) begin
            txShift  <= {1'b1, txByte, 1'b0};
            txBits   <= 4'h0;
            txActive <= 1'b1;
        end else if (txActive && bitTick) begin
            txShift  <= {1'b1, txShift[9:1]};
            txBits   <= txBits + 4'h1;
            txActive <= (txBits != 4'(FIELD_BITS - 1));
        end
    end

    //--------------------------------------------------------------------------
    // Receiver, sampled at mid bit
    //--------------------------------------------------------------------------
    logic       rxActive;
    logic [1:0] rxPhase;
    logic [3:0] rxBit;
    logic [7:0] rxShift;
    logic       rxStrobe;
    logic       rxBad;
    wire        rxSample = rxActive && (rxPhase == 2'h0);

    // Stop bit must be high; no parity bit is expected
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxActive <= 1'b0;
            rxPhase  <= 2'h0;
            rxBit    <= 4'h0;
            rxShift  <= 8'h00;
            rxStrobe <= 1'b0;
            rxBad    <= 1'b0;
        end else begin
            rxStrobe <= 1'b0;
            rxBad    <= 1'b0;
            if (!rxActive) begin
                if (!rxd) begin
                    rxActive <= 1'b1;
                    rxPhase  <= 2'(CYC_HALF_BIT - 1);
                    rxBit    <= 4'h0;
                end
            end else if (rxSample) begin
                rxPhase <= 2'(CYC_PER_BIT - 1);
                rxBit   <= rxBit + 4'h1;
                if (rxBit == 4'h0 && rxd) begin
                    rxActive <= 1'b0;                           // Glitch, not a start
                end else if (rxBit == 4'(FIELD_BITS - 1)) begin
                    rxActive <= 1'b0;
                    rxStrobe <= rxd;
                    rxBad    <= !rxd;
                end else if (rxBit != 4'h0) begin
                    rxShift <= {rxd, rxShift[7:1]};
                end
            end else begin
                rxPhase <= rxPhase - 2'h1;
            end
        end
    end

    //--------------------------------------------------------------------------
    // Two-entry reply buffer
    //--------------------------------------------------------------------------
    // The encoder cannot be paused, so a stall holds off completion and, with the buffer full, drops bytes and sets overrun
    logic [7:0] bufMem [DEPTH];
    logic [$clog2(DEPTH)-1:0] wrPtr;
    logic [$clog2(DEPTH)-1:0] rdPtr;
    logic [$clog2(DEPTH):0]   bufCount;
    wire  bufFull  = (bufCount == ($clog2(DEPTH)+1)'(DEPTH));
    wire  bufEmpty = (bufCount == '0);
    wire  bufPush  = rxStrobe && (state == ST_RECV) && !bufFull;
    wire  bufPop   = replyValid && replyReady;

    assign replyValid = !bufEmpty;
    assign replyData  = bufMem[rdPtr];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPtr    <= '0;
            rdPtr    <= '0;
            bufCount <= '0;
            for (int i = 0; i < DEPTH; i++) bufMem[i] <= 8'h00;
        end else begin
            if (bufPush) begin
                bufMem[wrPtr] <= rxShift;
                wrPtr <= (wrPtr == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (bufPop) rdPtr <= (rdPtr == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            bufCount <= bufCount + ($clog2(DEPTH)+1)'(bufPush) - ($clog2(DEPTH)+1)'(bufPop);
        end
    end

    //--------------------------------------------------------------------------
    // Transaction sequencer
    //--------------------------------------------------------------------------
    wire [3:0] rxLast   = replyLen(kind) - 4'h1;
    wire       lastByte = (rxIdx == rxLast);

    // Sequencing, echo check and reply CRC in one place
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state          <= ST_IDLE;
            kind           <= AELR_POS;
            addrHold       <= 8'h00;
            dataHold       <= 8'h00;
            reqIdx         <= 4'h0;
            rxIdx          <= 4'h0;
            txCrc          <= CRC_INIT;
            rxCrc          <= CRC_INIT;
            lastSent       <= 8'h00;
            transmitEnable <= 1'b0;
            done           <= 1'b0;
            crcOk          <= 1'b0;
            crcFail        <= 1'b0;
            frameError     <= 1'b0;
            echoError      <= 1'b0;
            overrun        <= 1'b0;
        end else begin
            done <= 1'b0;
            if (rxStrobe && state == ST_RECV && bufFull) overrun <= 1'b1;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        kind           <= transactionCode;
                        addrHold       <= memAddr;
                        dataHold       <= memData;
                        reqIdx         <= 4'h0;
                        rxIdx          <= 4'h0;
                        txCrc          <= CRC_INIT;
                        rxCrc          <= CRC_INIT;
                        crcOk          <= 1'b0;
                        crcFail        <= 1'b0;
                        frameError     <= 1'b0;
                        echoError      <= 1'b0;
                        overrun        <= 1'b0;
                        transmitEnable <= 1'b1;
                        state          <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (txLoad) begin
                        txCrc    <= crcStep(txCrc, txByte, CRC_POLY);
                        lastSent <= txByte;
                        state    <= ST_ECHO;
                    end
                end
                ST_ECHO: begin
                    // Own byte returns through the open receiver
                    if (rxStrobe || rxBad) begin
                        if (!rxStrobe || rxShift != lastSent) echoError <= 1'b1;
                        if (reqIdx == reqLast) begin
                            transmitEnable <= 1'b0;
                            state          <= ST_RECV;
                        end else begin
                            reqIdx <= reqIdx + 4'h1;
                            state  <= ST_SEND;
                        end
                    end
                end
                ST_RECV: begin
                    if (rxStrobe) begin
                        if (lastByte) begin
                            crcOk   <= (rxShift == rxCrc);
                            crcFail <= (rxShift != rxCrc);
                            state   <= ST_CHECK;
                        end else begin
                            // Control field must come back first
                            if (rxIdx == 4'h0 && rxShift != ctrlOf(kind)) echoError <= 1'b1;
                            rxCrc <= crcStep(rxCrc, rxShift, CRC_POLY);
                            rxIdx <= rxIdx + 4'h1;
                        end
                    end
                end
                ST_CHECK: begin
                    // Hold completion until the reader drained every byte
                    if (bufEmpty) begin
                        done  <= 1'b1;
                        state <= ST_DONE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // After the case, so a bad frame wins over the clear taken at start
            if (rxBad) frameError <= 1'b1;
        end
    end

    assign busy = (state != ST_IDLE);

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence sFieldBody;
        txActive ##39 txActive ##1 !txActive;
    endsequence

    a_field_length: assert property ($rose(txActive) |-> sFieldBody)
        else $error("transmit field not forty cycles long");
    a_start_low: assert property ($rose(txActive) |-> !txd ##4 (txd == $past(txByte[0], 5)))
        else $error("start bit not low or first payload bit not the LSB");
    a_delim_high: assert property ($rose(txActive) |-> ##37 txd)
        else $error("delimiter not high");
    a_ctrl_first: assert property (txLoad && reqIdx == 4'h0 |-> txByte == ctrlOf(kind))
        else $error("first field is not the control field");
    a_echo_waits: assert property (state == ST_ECHO |-> !txLoad && transmitEnable)
        else $error("new byte sent before the echo was read");
    a_req_count: assert property ($fell(transmitEnable) |-> reqIdx == reqLen(kind) - 4'h1)
        else $error("wrong number of request fields");
    a_enable_off: assert property (state inside {ST_RECV, ST_CHECK, ST_IDLE} |-> !transmitEnable)
        else $error("transmit enable on outside a request");
    a_crc_result: assert property ($past(state) == ST_RECV && state == ST_CHECK |-> crcOk != crcFail)
        else $error("CRC status not exclusive");
    a_done_late: assert property (done |-> $past(state) == ST_CHECK && $past(bufEmpty) && (crcOk || crcFail))
        else $error("completion before CRC status");

endmodule

// file: src/aelr_pkg.sv
// Constants, codes and helpers for the absolute encoder link receiver
//------------------------------------------------------------------------------
// Function
// - Each field: start bit, eight payload, delimiter.
// - Control payload holds code; others hold bytes.
// - Request always opens with control field.
// - Memory request: control, address, data(write), CRC.
// - Four readout transaction codes supported.
// - Three reset codes; reply carries position.
// - Code decides request and reply field counts.
// - Link runs at 2.5 Mbps both ways.
// - Dedicated transmit enable; receive always enabled.
// - Eight data bits, one stop, no parity.
// - Drop enable after last echo, collect reply.
// - Last reply byte is CRC; compare, report.
//------------------------------------------------------------------------------
package aelr_pkg;

    // Link timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned LINK_BPS      = 2_500_000;
    localparam int unsigned CYC_PER_BIT   = CLK_HZ / LINK_BPS;  // 4 cycles per bit
    localparam int unsigned CYC_HALF_BIT  = CYC_PER_BIT / 2;
    localparam int unsigned FIELD_BITS    = 10;

    // Transactions selectable by the host
    typedef enum logic [3:0] {
        AELR_POS       = 4'h0,
        AELR_TURNS     = 4'h1,
        AELR_IDENT     = 4'h2,
        AELR_ALL       = 4'h3,
        AELR_RST_POS   = 4'h4,
        AELR_RST_TURNS = 4'h5,
        AELR_RST_ERR   = 4'h6,
        AELR_MEM_RD    = 4'h7,
        AELR_MEM_WR    = 4'h8
    } aelr_kind_t;

    // Data field counts in each readout reply kind, total field count in a memory reply
    localparam logic [3:0] DATA_POS   = 4'h3;
    localparam logic [3:0] DATA_TURNS = 4'h3;
    localparam logic [3:0] DATA_IDENT = 4'h1;
    localparam logic [3:0] DATA_ALL   = 4'h8;
    localparam logic [3:0] MEM_REPLY  = 4'h4;   // control, address, data, CRC
    localparam logic [7:0] CRC_INIT   = 8'h00;

    // Control payload that carries the transaction code
    function automatic logic [7:0] ctrlOf(input aelr_kind_t k);
        return {4'h0, k};
    endfunction

    // Fields sent for each code
    function automatic logic [3:0] reqLen(input aelr_kind_t k);
        if (k == AELR_MEM_RD) return 4'h3;
        else if (k == AELR_MEM_WR) return 4'h4;
        else return 4'h1;
    endfunction

    // Fields expected back: control, status, data..., CRC; memory codes: control, address, data, CRC
    function automatic logic [3:0] replyLen(input aelr_kind_t k);
        case (k)
            AELR_TURNS:              return DATA_TURNS + 4'h3;
            AELR_IDENT:              return DATA_IDENT + 4'h3;
            AELR_ALL:                return DATA_ALL + 4'h3;
            AELR_MEM_RD, AELR_MEM_WR: return MEM_REPLY;
            default:                 return DATA_POS + 4'h3;
        endcase
    endfunction

    // One byte of CRC-8, LSB first
    function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d, input logic [7:0] poly);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ poly) : (r >> 1);
        end
        return r;
    endfunction

endpackage

// file: bench/aelr_encoder_model.sv
// Behavioural encoder at the far end of the half-duplex link, plus a bench CRC helper
package aelr_tb_pkg;
    localparam logic [7:0] TB_POLY = 8'h01;  // Same polynomial the receiver instance uses
    // Serial CRC-8, LSB first, written apart from the design so a shared slip cannot hide
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ TB_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage

module aelr_encoder_model
    import aelr_tb_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic txd,
    input  wire logic transmitEnable,
    input  wire logic corrupt,
    output wire logic rxd,
    output logic      frameBad
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       line;
    logic [7:0] b;
    logic [7:0] req [0:3];
    logic [7:0] sent [0:10];
    int         nReq;
    int         reqCount;

    // Receiver path never disabled, so our own driver's bits come straight back
    assign rxd = transmitEnable ? txd : line;

    // One field: low start, payload LSB first, high delimiter, four cycles a bit
    task automatic sendField(input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line = f[i];
            repeat (4) @(negedge clk_sys);
        end
    endtask

    // Reply shaped by the code: echoed control, then status or memory fields, CRC last
    task automatic reply();
        logic [7:0] c;
        int         n;
        case (req[0][3:0])
            4'h2:       n = 4;
            4'h3:       n = 11;
            4'h7, 4'h8: n = 4;
            default:    n = 6;  // resets reply like a position readout
        endcase
        sent[0] = req[0];
        for (int k = 1; k < n - 1; k++) sent[k] = 8'hA0 + 8'(k);
        if (req[0][3:0] == 4'h7 || req[0][3:0] == 4'h8) begin
            sent[1] = req[1];
            sent[2] = (req[0][3:0] == 4'h8) ? req[2] : 8'h5A;
        end
        c = 8'h00;
        for (int k = 0; k < n - 1; k++) c = crc8(c, sent[k]);
        sent[n - 1] = c ^ {7'h0, corrupt};  // bad CRC only when the bench asks
        repeat (6) @(negedge clk_sys);
        for (int k = 0; k < n; k++) sendField(sent[k]);
        line = 1'b1;  // Failsafe bias pulls the idle bus high
    endtask

    // Decode request fields at mid-bit; the reply starts once the driver lets go
    initial begin
        line = 1'b1;
        frameBad = 1'b0;
        nReq = 0;
        reqCount = 0;
        forever begin
            @(negedge clk_sys);
            if (transmitEnable === 1'b1 && txd === 1'b0) begin
                @(negedge clk_sys);
                for (int i = 0; i < 8; i++) begin
                    repeat (4) @(negedge clk_sys);
                    b[i] = txd;
                end
                repeat (4) @(negedge clk_sys);
                if (txd !== 1'b1) frameBad = 1'b1;
                if (nReq < 4) req[nReq] = b;
                nReq++;
            end else if (transmitEnable === 1'b0 && nReq > 0) begin
                reqCount = nReq;
                nReq = 0;
                reply();
            end
        end
    end
endmodule

// file: bench/absolute_encoder_link_receiver_bench.sv
// Self-checking bench for the link receiver against the encoder model
module absolute_encoder_link_receiver_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import aelr_pkg::*;
    import aelr_tb_pkg::*;
    logic clk_sys, rst, start, rxd, txd, transmitEnable, busy, done, crcOk, crcFail;
    logic frameError, echoError, overrun, replyValid, replyReady, corrupt, frameBad;
    aelr_kind_t transactionCode;
    logic [7:0] memAddr, memData, replyData;
    int nMismatch, numChecks;

    aelr_receiver dut_u (.clk_sys(clk_sys), .rst(rst), .start(start), .transactionCode(transactionCode),
        .memAddr(memAddr), .memData(memData), .rxd(rxd), .txd(txd), .transmitEnable(transmitEnable),
        .busy(busy), .done(done), .crcOk(crcOk), .crcFail(crcFail), .frameError(frameError),
        .echoError(echoError), .overrun(overrun), .replyData(replyData), .replyValid(replyValid),
        .replyReady(replyReady));
    aelr_encoder_model enc_u (.clk_sys(clk_sys), .txd(txd), .transmitEnable(transmitEnable),
        .corrupt(corrupt), .rxd(rxd), .frameBad(frameBad));

    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One transaction; stall holds ready low from the second valid cycle through the stall-th, poke retries start mid-run
    task automatic run(input aelr_kind_t k, input logic [7:0] a, input logic [7:0] d,
                       input logic bad, input int stall, input logic poke);
        int n, r, idx, waitc;
        logic seen;
        logic [7:0] c;
        n = (k == AELR_IDENT || k == AELR_MEM_RD || k == AELR_MEM_WR) ? 4 : (k == AELR_ALL ? 11 : 6);
        r = (k == AELR_MEM_RD) ? 3 : (k == AELR_MEM_WR ? 4 : 1);
        idx = 0;
        waitc = 0;
        seen = 1'b0;
        corrupt = bad;
        transactionCode = k;
        memAddr = a;
        memData = d;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        chk("transmitEnable", 8'(transmitEnable), 8'h01);
        for (int cyc = 0; cyc < 3000 && !seen; cyc++) begin
            @(negedge clk_sys);
            if (poke) start = (cyc == 10);  // Must be ignored while busy
            // Ready is settled first, so a count here matches the pop at the coming edge
            if (replyValid === 1'b1) waitc++;
            replyReady = (waitc == 1 || waitc > stall);
            if (replyValid === 1'b1 && replyReady === 1'b1) begin
                if (stall < 100) chk("replyData", replyData, enc_u.sent[idx]);
                chk("transmitEnable", 8'(transmitEnable), 8'h00);
                idx++;
            end
            if (done === 1'b1) seen = 1'b1;
        end
        if (!seen) begin
            nMismatch++;
            $display("unexpected done: expected 1, seen 0");
            end_sim();
        end
        chk("crcOk", 8'(crcOk), 8'(!bad));
        chk("crcFail", 8'(crcFail), 8'(bad));
        if (stall < 100) chk("reply count", 8'(idx), 8'(n));
        else chk("overrun", 8'(overrun), 8'h01);
        chk("echoError", 8'(echoError), 8'h00);
        chk("frameError", 8'(frameError), 8'h00);
        chk("control field", enc_u.req[0], {4'h0, k});
        chk("request fields", 8'(enc_u.reqCount), 8'(r));
        chk("request framing", 8'(frameBad), 8'h00);
        if (r > 1) begin
            c = 8'h00;
            for (int i = 0; i < r - 1; i++) c = crc8(c, enc_u.req[i]);
            chk("address field", enc_u.req[1], a);
            if (r == 4) chk("data field", enc_u.req[2], d);
            chk("request CRC", enc_u.req[r - 1], c);
        end
        @(negedge clk_sys);
        chk("done pulse", 8'(done), 8'h00);
        @(negedge clk_sys);
        chk("busy", 8'(busy), 8'h00);
        chk("transmitEnable", 8'(transmitEnable), 8'h00);
    endtask

    //--------------------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------------------
    task automatic t_codes();
        for (int i = 0; i < 9; i++) begin
            run(aelr_kind_t'(4'(i)), 8'hFF - 8'(i), 8'(i), 1'b0, 0, 1'b0);
        end
        $display("test codes finished");
    endtask

    task automatic t_crc_fail();
        run(AELR_POS, 8'h00, 8'h00, 1'b1, 0, 1'b0);
        run(AELR_RST_ERR, 8'h00, 8'h00, 1'b0, 0, 1'b0);
        $display("test crc finished");
    endtask

    task automatic t_busy_start();
        run(AELR_IDENT, 8'h00, 8'h00, 1'b0, 0, 1'b1);
        $display("test busy start finished");
    endtask

    task automatic t_stall();
        run(AELR_ALL, 8'h00, 8'h00, 1'b0, 60, 1'b0);
        run(AELR_ALL, 8'h00, 8'h00, 1'b0, 200, 1'b0);
        $display("test stall finished");
    endtask

    //--------------------------------------------------------------------------
    // Clock, reset and main sequence
    //--------------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        rst = 1'b1;
        start = 1'b0;
        transactionCode = AELR_POS;
        memAddr = 8'h00;
        memData = 8'h00;
        replyReady = 1'b1;
        corrupt = 1'b0;
        nMismatch = 0;
        numChecks = 0;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        chk("txd idle", 8'(txd), 8'h01);
        chk("replyValid idle", 8'(replyValid), 8'h00);
        t_codes();
        t_crc_fail();
        t_busy_start();
        t_stall();
        end_sim();
    end
endmodule
